// file: common/djp_pkg.sv
// package for the dual joystick port: constants and carrier types
package djp_pkg;
    // ****************************************
    // configuration indices and register
    // ****************************************
    localparam logic [7:0] DJP_CFG_BASE_HI_IDX = 8'h60;
    localparam logic [7:0] DJP_CFG_BASE_LO_IDX = 8'h61;
    localparam logic [15:0] DJP_STATE_OFFSET = 16'h0000;
    localparam logic [7:0] DJP_STATE_RESET = 8'h00;
    localparam logic [15:0] DJP_BASE_RESET = 16'h0000;
    localparam int DJP_PWR_STICK_BIT = 2;
    localparam logic [7:0] DJP_PWR_RESET = 8'h00;

    // ****************************************
    // carrier types
    // ****************************************
    // one bit per button: [0] stick1 button1, [1] stick1 button2, [2] stick2 button1, [3] stick2 button2
    typedef struct packed {
        logic stick2_button2;
        logic stick2_button1;
        logic stick1_button2;
        logic stick1_button1;
    } djp_buttons_s;

    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
        logic wr;
    } djp_cfg_wr_s;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
    } djp_io_s;
endpackage : djp_pkg

// file: test/djp_stick_model.sv
// stick model: rc charge per axis with comparator output
module djp_stick_model (
    input wire logic clk_i,
    input wire logic [3:0] discharge_i,
    output logic [3:0] threshold_o = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int charge [4];
    // each axis charges longer; a discharged pin drops its comparator
    always @(posedge clk_i) begin
        for (int k = 0; k < 4; k++) begin
            charge[k] <= discharge_i[k] ? 0 : charge[k] + 1;
            threshold_o[k] <= !discharge_i[k] && charge[k] >= 10 + 6 * k;
        end
    end
endmodule : djp_stick_model

// file: test/djp_top_monitor.sv
// port checker for the dual joystick port
module djp_top_monitor (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire djp_pkg::djp_io_s io_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rvalid_o,
    input wire logic [15:0] base_addr_o,
    input wire logic activate_o,
    input wire logic [7:0] power_control_config_o,
    input wire logic [3:0] axis_threshold_i,
    input wire logic [3:0] axis_timing_pins_discharge_o,
    input wire logic [3:0] axis_timer_outputs_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import djp_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic hit;
    assign hit = activate_o && io_i.addr == base_addr_o;
    sequence wr_end;
        hit && io_i.wr ##1 !io_i.wr;
    endsequence
    AST_RD_ANS: assert property (hit && io_i.rd |=> io_rvalid_o) else $error("read not answered");
    AST_NO_DEC: assert property (!activate_o |=> !io_rvalid_o) else $error("decode while off");
    AST_IDLE: assert property (!io_rvalid_o |-> io_rdata_o == 8'h00) else $error("data when idle");
    AST_MIRROR: assert property (activate_o == power_control_config_o[2]) else $error("no mirror");
    AST_RESTART: assert property (wr_end |-> ##[2:3] axis_timer_outputs_o == 4'hf) else $error("no restart");
    AST_LEAD: assert property (io_i.wr [*4] ##0 axis_timer_outputs_o == 4'h0 |=> axis_timer_outputs_o == 4'h0)
        else $error("restart on leading edge");
    AST_THR: assert property ($rose(axis_threshold_i[0]) |-> ##[1:5] !axis_timer_outputs_o[0])
        else $error("no clear");
    AST_DISCH: assert property (axis_timing_pins_discharge_o == ~axis_timer_outputs_o) else $error("pin mismatch");
endmodule : djp_top_monitor
bind djp_top djp_top_monitor djp_top_monitor_inst (.*);

// file: test/tb.sv
// self-checking bench for the dual joystick port
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import djp_pkg::*;
    logic clk_i = 0, arst_n_i = 0, activate_wr_i = 0, activate_data_i = 0, pwr_wr_i = 0, io_rvalid_o, activate_o;
    logic [7:0] pwr_data_i = 0, io_rdata_o, power_control_config_o;
    logic [15:0] base_addr_o;
    logic [3:0] axis_threshold_i, axis_timing_pins_discharge_o, axis_timer_outputs_o;
    djp_io_s io_i = '0;
    djp_cfg_wr_s cfg_i = '0;
    djp_buttons_s buttons_i = '0;
    int mismatches = 0, num_checks = 0;
    logic [8:0] d;
    djp_top djp_top_inst (.*);
    djp_stick_model djp_stick_model_inst (
        .clk_i(clk_i),
        .discharge_i(axis_timing_pins_discharge_o),
        .threshold_o(axis_threshold_i)
    );
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t %h %h", $time, e, g);
        end
    endtask : chk
    task automatic test_done;
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic rd(input logic [15:0] a);
        @(posedge clk_i);
        io_i <= '{a, 1'b1, 1'b0};
        @(posedge clk_i);
        io_i.rd <= 1'b0;
        #1;
        d = {io_rvalid_o, io_rdata_o};
    endtask : rd
    task automatic wr(input logic [15:0] a, input int n);
        @(posedge clk_i);
        io_i <= '{a, 1'b0, 1'b1};
        repeat (n) @(posedge clk_i);
        io_i.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic cfg(input logic [7:0] i, input logic [7:0] v);
        @(posedge clk_i);
        cfg_i <= '{i, v, 1'b1};
        @(posedge clk_i);
        cfg_i.wr <= 1'b0;
        #1;
    endtask : cfg
    task automatic ctl(input logic aw, input logic [7:0] p);
        @(posedge clk_i);
        {activate_wr_i, activate_data_i, pwr_wr_i, pwr_data_i} <= {aw, p[2], !aw, p};
        @(posedge clk_i);
        {activate_wr_i, pwr_wr_i} <= 2'b00;
        @(posedge clk_i);
        #1;
        chk({7'h0, p[2], aw ? (p & 8'h04) : p}, {7'h0, activate_o, power_control_config_o});
    endtask : ctl
    task automatic s_inactive;
        chk(8'h0f, {axis_timer_outputs_o, axis_timing_pins_discharge_o});
        chk(DJP_PWR_RESET, power_control_config_o);
        cfg(DJP_CFG_BASE_HI_IDX, 8'h12);
        cfg(DJP_CFG_BASE_LO_IDX, 8'h34);
        @(posedge clk_i);
        #1;
        chk(16'h1234, base_addr_o);
        wr(16'h1234, 1);
        rd(16'h1234);
        chk(16'h0000, {3'h0, d, axis_timer_outputs_o});
    endtask : s_inactive
    task automatic s_read;
        ctl(1'b1, 8'h04);
        ctl(1'b1, 8'h00);
        ctl(1'b0, 8'h04);
        @(posedge clk_i);
        buttons_i <= 4'ha;
        repeat (2) @(posedge clk_i);
        rd(16'h1234);
        chk(16'h01a0, {7'h0, d});
        rd(16'h1235);
        chk(16'h0000, {7'h0, d});
    endtask : s_read
    task automatic s_restart;
        wr(16'h1234, 6);
        chk(16'h000f, {axis_timer_outputs_o, axis_timing_pins_discharge_o});
        repeat (3) @(posedge clk_i);
        #1;
        chk(16'h00f0, {axis_timer_outputs_o, axis_timing_pins_discharge_o});
        rd(16'h1234);
        chk(16'h01af, {7'h0, d});
        for (int i = 0; i < 200 && d[3:0] !== 4'h0; i++) begin
            rd(16'h1234);
        end
        chk(16'h01a0, {7'h0, d});
        if (d[3:0] !== 4'h0) begin
            test_done();
        end
    endtask : s_restart
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        #1;
        s_inactive();
        s_read();
        s_restart();
        test_done();
    end
endmodule : tb

// file: verilog/djp_top.sv
// dual joystick port: io decode, axis one-shots, buttons, config shadows
// How it works
// - two sticks, each with x and y axis timers and two buttons
// - an io write at the base while activate is set restarts every axis pin and output
// - restart happens when the write strobe deasserts, not when it asserts
// - an axis clears its bit and discharges its pin at threshold
// - read gives buttons in bits 7..4 and axis outputs in bits 3..0
// - eight-bit read-only register; written data is dropped
// - register reads zero after power-on reset
// - io read at base is a state read, io write is a restart
// - base address high byte from index 0x60, low byte from 0x61
// - no decode at the base while activate is clear
// - power control bit 2 and activate bit always mirror each other
module djp_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire djp_pkg::djp_io_s io_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    input wire djp_pkg::djp_cfg_wr_s cfg_i,
    input wire logic activate_wr_i,
    input wire logic activate_data_i,
    input wire logic pwr_wr_i,
    input wire logic [7:0] pwr_data_i,
    output logic [15:0] base_addr_o,
    output logic activate_o,
    output logic [7:0] power_control_config_o,
    input wire logic [3:0] axis_threshold_i,
    input wire djp_pkg::djp_buttons_s buttons_i,
    output logic [3:0] axis_timing_pins_discharge_o,
    output logic [3:0] axis_timer_outputs_o
);
    import djp_pkg::*;

    // ****************************************
    // configuration shadows
    // ****************************************
    logic [15:0] base_reg;
    logic [7:0] pwr_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            base_reg <= DJP_BASE_RESET;
        end else if (cfg_i.wr && cfg_i.index == DJP_CFG_BASE_HI_IDX) begin
            base_reg[15:8] <= cfg_i.data;
        end else if (cfg_i.wr && cfg_i.index == DJP_CFG_BASE_LO_IDX) begin
            base_reg[7:0] <= cfg_i.data;
        end
    end

    // activate and power bit share one flop, so each write shows in both; a power write overrides a same-cycle activate write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwr_reg <= DJP_PWR_RESET;
        end else if (pwr_wr_i) begin
            pwr_reg <= pwr_data_i;
        end else if (activate_wr_i) begin
            pwr_reg[DJP_PWR_STICK_BIT] <= activate_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            base_addr_o <= DJP_BASE_RESET;
        end else begin
            base_addr_o <= base_reg;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_control_config_o <= DJP_PWR_RESET;
        end else begin
            power_control_config_o <= pwr_reg;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            activate_o <= 1'b0;
        end else begin
            activate_o <= pwr_reg[DJP_PWR_STICK_BIT];
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] thr_meta_reg;
    logic [3:0] thr_sync_reg;
    logic [3:0] btn_meta_reg;
    logic [3:0] btn_sync_reg;

    // two stages before anything reads a pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            thr_meta_reg <= 4'h0;
            thr_sync_reg <= 4'h0;
        end else begin
            thr_meta_reg <= axis_threshold_i;
            thr_sync_reg <= thr_meta_reg;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            btn_meta_reg <= 4'h0;
            btn_sync_reg <= 4'h0;
        end else begin
            btn_meta_reg <= buttons_i;
            btn_sync_reg <= btn_meta_reg;
        end
    end

    // ****************************************
    // io decode
    // ****************************************
    // one-hot strobe tracker; illegal codes fall back to idle
    typedef enum logic [1:0] {
        STROBE_IDLE = 2'b01,
        STROBE_HELD = 2'b10
    } djp_strobe_e;

    logic hit;
    logic wr_seen;
    logic restart;
    djp_strobe_e strobe_reg;
    djp_strobe_e strobe_next;

    assign hit = pwr_reg[DJP_PWR_STICK_BIT] && (io_i.addr == base_reg + DJP_STATE_OFFSET);
    assign wr_seen = io_i.wr && hit;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strobe_reg <= STROBE_IDLE;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    // restart only when a held decoded write strobe drops
    always_comb begin
        strobe_next = strobe_reg;
        restart = 1'b0;
        unique case (strobe_reg)
            STROBE_IDLE: begin
                if (wr_seen) begin
                    strobe_next = STROBE_HELD;
                end
            end
            STROBE_HELD: begin
                if (!wr_seen) begin
                    strobe_next = STROBE_IDLE;
                    restart = 1'b1;
                end
            end
            default: begin
                strobe_next = STROBE_IDLE;
            end
        endcase
    end

    // ****************************************
    // axis one-shots
    // ****************************************
    logic [3:0] axis_reg;

    generate
        for (genvar g = 0; g < 4; g++) begin : g_axis
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    axis_reg[g] <= 1'b0;
                end else if (restart) begin
                    axis_reg[g] <= 1'b1;
                end else if (thr_sync_reg[g]) begin
                    axis_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // discharge held while output low, released on restart
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            axis_timing_pins_discharge_o <= 4'hf;
        end else begin
            axis_timing_pins_discharge_o <= ~axis_reg;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            axis_timer_outputs_o <= 4'h0;
        end else begin
            axis_timer_outputs_o <= axis_reg;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    logic [7:0] state_word;

    assign state_word = {btn_sync_reg, axis_reg};

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_i.rd && hit;
        end
    end

    // idle cycles drive zero so a stale word never lingers on the bus
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_rdata_o <= DJP_STATE_RESET;
        end else if (io_i.rd && hit) begin
            io_rdata_o <= state_word;
        end else begin
            io_rdata_o <= DJP_STATE_RESET;
        end
    end
endmodule : djp_top
